// ---- shared/stop_wake_regs.vh ----
`ifndef STOP_WAKE_REGS_VH
`define STOP_WAKE_REGS_VH

// ------------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------------
`define PWR_CONTROL_OFS 6'h00
`define OSC_CONTROL_OFS 6'h04
`define AUTOGATE_OFS 6'h08
`define STATUS_OFS 6'h0C
`define WAKE_INT_POL_OFS 6'h10
`define WAKE_INT_RAW_OFS 6'h14
`define WAKE_INT_EN_OFS 6'h18
`define WAKE_INT_MASKED_OFS 6'h1C
`define WAKE_PIN_POL_OFS 6'h20
`define WAKE_PIN_RAW_OFS 6'h24
`define WAKE_PIN_EN_OFS 6'h28
`define WAKE_PIN_MASKED_OFS 6'h2C

// ------------------------------------------------------------------
// Power control fields and reset values
// ------------------------------------------------------------------
`define PC_STOP_BIT 0
`define PC_VSEL_BIT 1
`define PC_CKOVR_BIT 3
`define PC_CKLVL_BIT 4
`define PC_VLVL_BIT 5
`define PC_AUTOREL_BIT 7
`define PC_LOAD_BIT 8
`define PC_SREF_BIT 9
`define PC_WIDTH 10
`define PC_RESET 10'h000
`define PC_WMASK 10'h3BB
`define OSC_DIS_BIT 0
`define OSC_RESET 1'b0

// ------------------------------------------------------------------
// Timing counts
// ------------------------------------------------------------------
`define RESET_STRETCH_CYCLES 16
`define AUTOGATE_IDLE_CYCLES 16

`endif

// ---- hw/stop_mode_wake_controller.v ----
// Local design decisions: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "stop_wake_regs.vh"

module stop_mode_wake_controller #(
  parameter N_INT = 16,
  parameter N_PIN = 16,
  parameter N_PERIPH = 4,
  parameter IDLE_CYCLES = `AUTOGATE_IDLE_CYCLES,
  parameter IDLE_W = 8
) (
  input wire clk,
  input wire sys_rst,
  input wire [5:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  input wire [N_INT-1:0] wake_int_src,
  input wire [N_PIN-1:0] wake_pin_src,
  input wire [N_PERIPH-1:0] periph_access,
  output wire [N_PERIPH-1:0] periph_clk_en,
  output reg system_clock_enable,
  output reg core_voltage_level_pin,
  output reg sdram_selfrefresh_request,
  output reg ext_clock_request_pin_out,
  output reg ext_clock_request_pin_oe,
  output reg main_oscillator_clock_enable,
  output reg internal_reset
);

  // ------------------------------------------------------------------
  // States
  // ------------------------------------------------------------------
  localparam [1:0] ST_RUN = 2'b01;
  localparam [1:0] ST_STOP = 2'b10;

  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [`PC_WIDTH-1:0] power_control_reg;
  reg osc_disable_reg;
  reg [N_PERIPH-1:0] autogate_disable_reg;
  reg [N_INT-1:0] wake_polarity_internal_set;
  reg [N_PIN-1:0] wake_polarity_pin_set;
  reg [N_INT-1:0] wake_raw_status_internal_set;
  reg [N_PIN-1:0] wake_raw_status_pin_set;
  reg [N_INT-1:0] wake_enable_internal_set;
  reg [N_PIN-1:0] wake_enable_pin_set;
  reg ack_reg;
  reg load_prev_reg;
  reg [4:0] stretch_reg;

  wire [N_INT-1:0] wake_masked_status_internal_set;
  wire [N_PIN-1:0] wake_masked_status_pin_set;
  wire [N_INT-1:0] int_event;
  wire [N_PIN-1:0] pin_event;
  wire wr_en;
  wire rd_en;
  wire stop_mode;
  wire wake_activated;
  wire stop_bit;

  // ------------------------------------------------------------------
  // Bus slave: each access waits one cycle, then completes.
  // ------------------------------------------------------------------
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
  assign wr_en = avs_write & ack_reg;
  assign rd_en = avs_read & ~ack_reg;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (avs_read | avs_write) & ~ack_reg;
    end
  end

  // ------------------------------------------------------------------
  // Wake source qualification
  // ------------------------------------------------------------------
  // Sources arrive from logic that keeps running without the base clock,
  // so each one is synchronised here before it can touch the latches.
  genvar gi;
  generate
    for (gi = 0; gi < N_INT + N_PIN; gi = gi + 1) begin : g_src
      reg s1_reg;
      reg s2_reg;
      reg s3_reg;
      reg stable_reg;
      wire src;
      wire pol;
      wire agree;
      if (gi < N_INT) begin : g_int
        assign src = wake_int_src[gi];
        assign pol = wake_polarity_internal_set[gi];
        assign int_event[gi] = agree & (s2_reg == pol) & (stable_reg != pol);
      end else begin : g_pin
        assign src = wake_pin_src[gi-N_INT];
        assign pol = wake_polarity_pin_set[gi-N_INT];
        assign pin_event[gi-N_INT] = agree & (s2_reg == pol) & (stable_reg != pol);
      end
      assign agree = (s2_reg == s3_reg) & (s2_reg != stable_reg);
      always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          s1_reg <= 1'b0;
          s2_reg <= 1'b0;
          s3_reg <= 1'b0;
          stable_reg <= 1'b0;
        end else begin
          s1_reg <= src;
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          if (agree) begin
            stable_reg <= s2_reg;
          end
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------------
  // Wake latches and combination
  // ------------------------------------------------------------------
  assign wake_masked_status_internal_set =
    wake_raw_status_internal_set & wake_enable_internal_set;
  assign wake_masked_status_pin_set =
    wake_raw_status_pin_set & wake_enable_pin_set;
  // Events of this very cycle count too, so a wake that coincides with
  // the stop request still blocks entry.
  assign wake_activated =
    (|((wake_raw_status_internal_set | int_event) & wake_enable_internal_set))
    | (|((wake_raw_status_pin_set | pin_event) & wake_enable_pin_set));

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wake_raw_status_internal_set <= {N_INT{1'b0}};
      wake_raw_status_pin_set <= {N_PIN{1'b0}};
    end else begin
      // Clear by writing one; a new event in the same cycle wins.
      if (wr_en && avs_address == `WAKE_INT_RAW_OFS) begin
        wake_raw_status_internal_set <=
          (wake_raw_status_internal_set & ~avs_writedata[N_INT-1:0])
          | int_event;
      end else begin
        wake_raw_status_internal_set <= wake_raw_status_internal_set
          | int_event;
      end
      if (wr_en && avs_address == `WAKE_PIN_RAW_OFS) begin
        wake_raw_status_pin_set <=
          (wake_raw_status_pin_set & ~avs_writedata[N_PIN-1:0])
          | pin_event;
      end else begin
        wake_raw_status_pin_set <= wake_raw_status_pin_set | pin_event;
      end
    end
  end

  // ------------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------------
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      osc_disable_reg <= `OSC_RESET;
      autogate_disable_reg <= {N_PERIPH{1'b0}};
      wake_polarity_internal_set <= {N_INT{1'b0}};
      wake_polarity_pin_set <= {N_PIN{1'b0}};
      wake_enable_internal_set <= {N_INT{1'b0}};
      wake_enable_pin_set <= {N_PIN{1'b0}};
    end else if (wr_en) begin
      case (avs_address)
        `OSC_CONTROL_OFS: begin
          osc_disable_reg <= avs_writedata[`OSC_DIS_BIT];
        end
        `AUTOGATE_OFS: begin
          autogate_disable_reg <= avs_writedata[N_PERIPH-1:0];
        end
        `WAKE_INT_POL_OFS: begin
          wake_polarity_internal_set <= avs_writedata[N_INT-1:0];
        end
        `WAKE_INT_EN_OFS: begin
          wake_enable_internal_set <= avs_writedata[N_INT-1:0];
        end
        `WAKE_PIN_POL_OFS: begin
          wake_polarity_pin_set <= avs_writedata[N_PIN-1:0];
        end
        `WAKE_PIN_EN_OFS: begin
          wake_enable_pin_set <= avs_writedata[N_PIN-1:0];
        end
        default: begin
          osc_disable_reg <= osc_disable_reg;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Power control register and stop sequencing
  // ------------------------------------------------------------------
  assign stop_mode = state_reg[1];
  assign stop_bit = power_control_reg[`PC_STOP_BIT];

  always @* begin
    case (state_reg)
      ST_RUN: begin
        if (stop_bit && !wake_activated) begin
          state_next = ST_STOP;
        end else begin
          state_next = ST_RUN;
        end
      end
      ST_STOP: begin
        if (wake_activated) begin
          state_next = ST_RUN;
        end else begin
          state_next = ST_STOP;
        end
      end
      default: begin
        state_next = ST_RUN;
      end
    endcase
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= ST_RUN;
      power_control_reg <= `PC_RESET;
      load_prev_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      load_prev_reg <= power_control_reg[`PC_LOAD_BIT];
      if (wr_en && avs_address == `PWR_CONTROL_OFS) begin
        power_control_reg <= avs_writedata[`PC_WIDTH-1:0] & `PC_WMASK;
      end else if (stop_mode && wake_activated) begin
        power_control_reg[`PC_STOP_BIT] <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // Clock gate, core voltage and clock request pins
  // ------------------------------------------------------------------
  // The gate enable is a flop output, so a downstream latch-based cell
  // only ever sees it change away from the clock's active phase.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      system_clock_enable <= 1'b1;
      core_voltage_level_pin <= 1'b0;
      ext_clock_request_pin_out <= 1'b1;
      ext_clock_request_pin_oe <= 1'b1;
    end else begin
      system_clock_enable <= state_next[0];
      if (power_control_reg[`PC_VSEL_BIT]) begin
        core_voltage_level_pin <= power_control_reg[`PC_VLVL_BIT];
      end else begin
        core_voltage_level_pin <= state_next[1];
      end
      if (power_control_reg[`PC_CKOVR_BIT]) begin
        ext_clock_request_pin_out <= power_control_reg[`PC_CKLVL_BIT];
        ext_clock_request_pin_oe <= 1'b1;
      end else begin
        ext_clock_request_pin_out <= 1'b1;
        ext_clock_request_pin_oe <= ~state_next[1];
      end
    end
  end

  // ------------------------------------------------------------------
  // SDRAM self-refresh request
  // ------------------------------------------------------------------
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sdram_selfrefresh_request <= 1'b0;
    end else if (load_prev_reg && !power_control_reg[`PC_LOAD_BIT]) begin
      sdram_selfrefresh_request <= power_control_reg[`PC_SREF_BIT];
    end else if (stop_mode && wake_activated
                 && power_control_reg[`PC_AUTOREL_BIT]
                 && !power_control_reg[`PC_SREF_BIT]) begin
      sdram_selfrefresh_request <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Bus clock autogating
  // ------------------------------------------------------------------
  generate
    for (gi = 0; gi < N_PERIPH; gi = gi + 1) begin : g_auto
      reg [IDLE_W-1:0] idle_reg;
      reg on_reg;
      always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          idle_reg <= {IDLE_W{1'b0}};
          on_reg <= 1'b0;
        end else if (periph_access[gi]) begin
          idle_reg <= {IDLE_W{1'b0}};
          on_reg <= 1'b1;
        end else if (on_reg) begin
          if (idle_reg == IDLE_CYCLES[IDLE_W-1:0] - 1'b1) begin
            on_reg <= 1'b0;
          end
          idle_reg <= idle_reg + 1'b1;
        end
      end
      // The access itself opens the clock combinationally, so the first
      // cycle of an access is never lost.
      assign periph_clk_en[gi] = autogate_disable_reg[gi] | on_reg
        | periph_access[gi];
    end
  endgenerate

  // ------------------------------------------------------------------
  // Oscillator gate and reset stretcher
  // ------------------------------------------------------------------
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      main_oscillator_clock_enable <= 1'b0;
      internal_reset <= 1'b1;
      stretch_reg <= 5'h00;
    end else begin
      main_oscillator_clock_enable <= ~osc_disable_reg;
      if (stretch_reg == `RESET_STRETCH_CYCLES - 1) begin
        internal_reset <= 1'b0;
      end else begin
        stretch_reg <= stretch_reg + 5'h01;
      end
    end
  end

  // ------------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------------
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      avs_readdata <= 32'h00000000;
    end else if (rd_en) begin
      avs_readdata <= 32'h00000000;
      case (avs_address)
        `PWR_CONTROL_OFS: begin
          avs_readdata[`PC_WIDTH-1:0] <= power_control_reg;
        end
        `OSC_CONTROL_OFS: begin
          avs_readdata[0] <= osc_disable_reg;
        end
        `AUTOGATE_OFS: begin
          avs_readdata[N_PERIPH-1:0] <= autogate_disable_reg;
        end
        `STATUS_OFS: begin
          avs_readdata[2:0] <= {wake_activated, sdram_selfrefresh_request,
                                stop_mode};
        end
        `WAKE_INT_POL_OFS: begin
          avs_readdata[N_INT-1:0] <= wake_polarity_internal_set;
        end
        `WAKE_INT_RAW_OFS: begin
          avs_readdata[N_INT-1:0] <= wake_raw_status_internal_set;
        end
        `WAKE_INT_EN_OFS: begin
          avs_readdata[N_INT-1:0] <= wake_enable_internal_set;
        end
        `WAKE_INT_MASKED_OFS: begin
          avs_readdata[N_INT-1:0] <= wake_masked_status_internal_set;
        end
        `WAKE_PIN_POL_OFS: begin
          avs_readdata[N_PIN-1:0] <= wake_polarity_pin_set;
        end
        `WAKE_PIN_RAW_OFS: begin
          avs_readdata[N_PIN-1:0] <= wake_raw_status_pin_set;
        end
        `WAKE_PIN_EN_OFS: begin
          avs_readdata[N_PIN-1:0] <= wake_enable_pin_set;
        end
        `WAKE_PIN_MASKED_OFS: begin
          avs_readdata[N_PIN-1:0] <= wake_masked_status_pin_set;
        end
        default: begin
          avs_readdata <= 32'h00000000;
        end
      endcase
    end
  end

endmodule // stop_mode_wake_controller

`default_nettype wire

// ---- tb/stop_wake_props.sv ----
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Port level checks of the stop controller
// ----------------------------------------
module stop_wake_props #(
  parameter int IDLE_CYCLES = 4
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic avs_waitrequest,
  input wire logic [3:0] periph_access,
  input wire logic [3:0] periph_clk_en,
  input wire logic system_clock_enable,
  input wire logic core_voltage_level_pin,
  input wire logic sdram_selfrefresh_request,
  input wire logic ext_clock_request_pin_out,
  input wire logic ext_clock_request_pin_oe,
  input wire logic internal_reset
);
  // A shadow of the control word lets the pin rules be judged here.
  logic [9:0] pc_q;
  logic [4:0] rel_cnt;
  logic [7:0] idle0;
  logic dis0;
  logic wr_ack;
  assign wr_ack = avs_write && !avs_waitrequest;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pc_q <= 10'h000;
      rel_cnt <= 5'h00;
      idle0 <= 8'hFF;
      dis0 <= 1'b0;
    end else begin
      if (wr_ack && avs_address == 6'h00)
        pc_q <= avs_writedata[9:0];
      if (wr_ack && avs_address == 6'h08)
        dis0 <= avs_writedata[0];
      if (rel_cnt != 5'h10)
        rel_cnt <= rel_cnt + 5'h01;
      if (periph_access[0])
        idle0 <= 8'h00;
      else if (idle0 != 8'hFF)
        idle0 <= idle0 + 8'h01;
    end
  end
  sequence pc_held;
    $stable(pc_q) ##1 $stable(pc_q);
  endsequence
  sequence one_wait;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  sequence load_fall;
    wr_ack && avs_address == 6'h00 && avs_writedata[9:8] == 2'b10
      && pc_q[9:8] == 2'b11;
  endsequence
  core_sel0_a: assert property (pc_held ##0 (!pc_q[1] &&
    $stable(system_clock_enable)) |->
    core_voltage_level_pin == !system_clock_enable)
    else $error("core pin does not follow stop state");
  core_sel1_a: assert property (pc_held ##0 pc_q[1] |->
    core_voltage_level_pin == pc_q[5])
    else $error("core pin does not follow level bit");
  clkreq_ovr_a: assert property (pc_held ##0 pc_q[3] |->
    ext_clock_request_pin_oe && ext_clock_request_pin_out == pc_q[4])
    else $error("clock request override wrong");
  clkreq_run_a: assert property (pc_held ##0 (!pc_q[3] &&
    system_clock_enable && $stable(system_clock_enable)) |->
    ext_clock_request_pin_oe && ext_clock_request_pin_out)
    else $error("clock request not driven high in run");
  reset_stretch_a: assert property (
    internal_reset == (rel_cnt < 5'h10))
    else $error("internal reset length wrong");
  sref_request_a: assert property (load_fall |->
    ##[2:3] sdram_selfrefresh_request)
    else $error("self refresh request not raised");
  sref_release_a: assert property ($rose(system_clock_enable)
    && pc_q[7] && !pc_q[9] |-> ##[0:1] !sdram_selfrefresh_request)
    else $error("self refresh request not released");
  bus_wait_a: assert property ($rose(avs_read || avs_write) |-> one_wait)
    else $error("wait request not exactly one cycle");
  gate_on_a: assert property (idle0 < IDLE_CYCLES - 1 |->
    periph_clk_en[0])
    else $error("bus clock gated too early");
  gate_off_a: assert property (idle0 > IDLE_CYCLES + 1 && !dis0
    && !periph_access[0] |-> !periph_clk_en[0])
    else $error("bus clock not gated when idle");
endmodule // stop_wake_props
bind stop_mode_wake_controller stop_wake_props #(
  .IDLE_CYCLES(IDLE_CYCLES)) u_props (.clk(clk), .sys_rst(sys_rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
  .periph_access(periph_access), .periph_clk_en(periph_clk_en),
  .system_clock_enable(system_clock_enable),
  .core_voltage_level_pin(core_voltage_level_pin),
  .sdram_selfrefresh_request(sdram_selfrefresh_request),
  .ext_clock_request_pin_out(ext_clock_request_pin_out),
  .ext_clock_request_pin_oe(ext_clock_request_pin_oe),
  .internal_reset(internal_reset));
`default_nettype wire

// ---- tb/supply_sdram_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Power supply and memory controller model
// ----------------------------------------
module supply_sdram_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic core_voltage_level_pin,
  input wire logic sdram_selfrefresh_request,
  input wire logic ext_clock_request_pin_out,
  input wire logic ext_clock_request_pin_oe,
  output logic core_lowered,
  output logic sref_active,
  output logic clk_req_line
);
  logic sref_dly;
  logic last_drv;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      core_lowered <= 1'b0;
      sref_dly <= 1'b0;
      sref_active <= 1'b0;
      last_drv <= 1'b1;
    end else begin
      // The supply lowers only while the pin allows it.
      core_lowered <= core_voltage_level_pin;
      sref_dly <= sdram_selfrefresh_request;
      sref_active <= sref_dly;
      if (ext_clock_request_pin_oe)
        last_drv <= ext_clock_request_pin_out;
    end
  end
  // A released pin has no keeper, so it must not show a stale level.
  assign clk_req_line = ext_clock_request_pin_oe ?
    ext_clock_request_pin_out : ~last_drv;
endmodule // supply_sdram_model
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "stop_wake_regs.vh"
// ----------------------------------------
// Scenario bench
// ----------------------------------------
module tb;
  logic clk, sys_rst, avs_read, avs_write, avs_waitrequest;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rdata;
  logic [15:0] wake_int_src, wake_pin_src;
  logic [3:0] periph_access, periph_clk_en;
  logic system_clock_enable, core_voltage_level_pin, internal_reset;
  logic sdram_selfrefresh_request, main_oscillator_clock_enable;
  logic ext_clock_request_pin_out, ext_clock_request_pin_oe;
  logic core_lowered, sref_active, clk_req_line;
  int errors = 0;
  int total_checks = 0;
  int n;
  stop_mode_wake_controller #(.IDLE_CYCLES(4)) DUT (.clk(clk),
    .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .wake_int_src(wake_int_src), .wake_pin_src(wake_pin_src),
    .periph_access(periph_access), .periph_clk_en(periph_clk_en),
    .system_clock_enable(system_clock_enable),
    .core_voltage_level_pin(core_voltage_level_pin),
    .sdram_selfrefresh_request(sdram_selfrefresh_request),
    .ext_clock_request_pin_out(ext_clock_request_pin_out),
    .ext_clock_request_pin_oe(ext_clock_request_pin_oe),
    .main_oscillator_clock_enable(main_oscillator_clock_enable),
    .internal_reset(internal_reset));
  supply_sdram_model supply (.clk(clk), .sys_rst(sys_rst),
    .core_voltage_level_pin(core_voltage_level_pin),
    .sdram_selfrefresh_request(sdram_selfrefresh_request),
    .ext_clock_request_pin_out(ext_clock_request_pin_out),
    .ext_clock_request_pin_oe(ext_clock_request_pin_oe),
    .core_lowered(core_lowered), .sref_active(sref_active),
    .clk_req_line(clk_req_line));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // The request is held until the edge that samples waitrequest low.
  task automatic acc(input logic w, input logic [5:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rdata = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic rst_test;
    @(posedge clk);
    sys_rst <= 1'b1;
    #1;
    check(internal_reset, 1);
    check(core_voltage_level_pin, 0);
    check(main_oscillator_clock_enable, 0);
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (internal_reset === 1'b1 && n < 40);
    check(n, 17);
    check(main_oscillator_clock_enable, 1);
    acc(0, `PWR_CONTROL_OFS, 0);
    check(rdata, `PC_RESET);
    acc(0, `OSC_CONTROL_OFS, 0);
    check(rdata, 0);
    $display("reset test done");
  endtask
  task automatic wake_test;
    acc(1, `WAKE_INT_POL_OFS, 32'h0000_0001);
    acc(1, `WAKE_PIN_POL_OFS, 32'h0000_0000);
    acc(1, `WAKE_PIN_EN_OFS, 32'h0000_0008);
    @(posedge clk);
    wake_int_src <= 16'h0003;
    wake_pin_src <= 16'hFFF7;
    repeat (8) @(posedge clk);
    acc(0, `WAKE_INT_RAW_OFS, 0);
    check(rdata, 32'h0000_0001);
    acc(0, `WAKE_PIN_RAW_OFS, 0);
    check(rdata, 32'h0000_0008);
    acc(0, `WAKE_INT_MASKED_OFS, 0);
    check(rdata, 0);
    acc(0, `WAKE_PIN_MASKED_OFS, 0);
    check(rdata, 32'h0000_0008);
    acc(1, `WAKE_PIN_EN_OFS, 0);
    acc(1, `WAKE_INT_RAW_OFS, 32'h0000_FFFF);
    acc(1, `WAKE_PIN_RAW_OFS, 32'h0000_FFFF);
    acc(0, `WAKE_INT_RAW_OFS, 0);
    check(rdata, 0);
    $display("wake test done");
  endtask
  task automatic stop_test;
    acc(1, `PWR_CONTROL_OFS, 32'h0000_0300);
    acc(1, `PWR_CONTROL_OFS, 32'h0000_0200);
    repeat (4) @(posedge clk);
    check(sdram_selfrefresh_request, 1);
    check(sref_active, 1);
    acc(1, `PWR_CONTROL_OFS, 32'h0000_0080);
    acc(1, `WAKE_INT_POL_OFS, 32'h0000_0005);
    acc(1, `WAKE_INT_EN_OFS, 32'h0000_0004);
    acc(1, `PWR_CONTROL_OFS, 32'h0000_0081);
    repeat (3) @(posedge clk);
    check(system_clock_enable, 0);
    check(core_voltage_level_pin, 1);
    check(core_lowered, 1);
    check(ext_clock_request_pin_oe, 0);
    check(sdram_selfrefresh_request, 1);
    @(posedge clk);
    wake_int_src <= 16'h0007;
    repeat (8) @(posedge clk);
    check(system_clock_enable, 1);
    check(core_voltage_level_pin, 0);
    check({ext_clock_request_pin_oe, clk_req_line}, 2'b11);
    check(sdram_selfrefresh_request, 0);
    acc(0, `PWR_CONTROL_OFS, 0);
    check(rdata[0], 0);
    if (rdata[0] !== 1'b0)
      acc(1, `PWR_CONTROL_OFS, 0);
    // The wake latch is still set, so this request must be refused.
    acc(1, `PWR_CONTROL_OFS, 32'h0000_0001);
    repeat (3) @(posedge clk);
    check(system_clock_enable, 1);
    acc(0, `PWR_CONTROL_OFS, 0);
    check(rdata[0], 1);
    acc(0, `STATUS_OFS, 0);
    check(rdata, 32'h0000_0004);
    acc(1, `PWR_CONTROL_OFS, 0);
    acc(1, `WAKE_INT_RAW_OFS, 32'h0000_FFFF);
    $display("stop test done");
  endtask
  task automatic pin_test;
    acc(1, `PWR_CONTROL_OFS, 32'h0000_0022);
    repeat (3) @(posedge clk);
    check(core_voltage_level_pin, 1);
    acc(1, `PWR_CONTROL_OFS, 32'h0000_0002);
    repeat (3) @(posedge clk);
    check(core_voltage_level_pin, 0);
    acc(1, `PWR_CONTROL_OFS, 32'h0000_0008);
    repeat (3) @(posedge clk);
    check({ext_clock_request_pin_oe, clk_req_line}, 2'b10);
    acc(1, `PWR_CONTROL_OFS, 32'h0000_0018);
    repeat (3) @(posedge clk);
    check({ext_clock_request_pin_oe, clk_req_line}, 2'b11);
    acc(1, `PWR_CONTROL_OFS, 0);
    $display("pin test done");
  endtask
  task automatic gate_test;
    @(posedge clk);
    periph_access <= 4'h1;
    @(posedge clk);
    periph_access <= 4'h0;
    repeat (2) @(posedge clk);
    check(periph_clk_en[0], 1);
    repeat (8) @(posedge clk);
    check(periph_clk_en[0], 0);
    acc(1, `AUTOGATE_OFS, 32'h0000_0002);
    @(posedge clk);
    check(periph_clk_en[1], 1);
    acc(1, `AUTOGATE_OFS, 0);
    acc(1, 6'h30, 32'hFFFF_FFFF);
    acc(0, 6'h30, 0);
    check(rdata, 0);
    $display("gate test done");
  endtask
  initial begin
    sys_rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 6'h00;
    avs_writedata = 32'h0000_0000;
    wake_int_src = 16'h0000;
    wake_pin_src = 16'hFFFF;
    periph_access = 4'h0;
    rst_test();
    wake_test();
    stop_test();
    pin_test();
    gate_test();
    rst_test();
    end_sim();
  end
  // The scenarios need well under two thousand cycles.
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    end_sim();
  end
endmodule // tb
`default_nettype wire
